/* logic/gain_code_shifter.sv */
/*
  gain_code_shifter: six-bit serial shift register on the link clock.
  assumes: i_link_clk runs only while the host drives the serial clock; the
  load window is sampled on the same edge as the data, as the pin does.
*/
`timescale 1ns/10ps
`default_nettype none
module gain_code_shifter
  import gain_ctrl_pkg::*;
(
  input  wire logic                i_link_clk,
  input  wire logic                i_sys_rst,
  input  wire gain_ctrl_pkg::serial_pins_s i_pins,
  output logic [5:0]               o_shift
);

  logic [5:0] shift_reg;
  logic [5:0] shift_next;

  // ----------------------------------------------------------------
  // shift msb first, only inside the load window
  // ----------------------------------------------------------------
  always_comb begin
    shift_next = shift_reg;
    if (!i_pins.load_window_n) begin
      // older words of eight bits simply push the two leading bits out
      shift_next = {shift_reg[4:0], i_pins.serial_gain_in};
    end
  end

  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_reg <= CODE_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  assign o_shift = shift_reg;

endmodule
`default_nettype wire

/* logic/serial_gain_control.sv */
/*
  serial_gain_control: control logic of a cable line driver. takes a gain
  code over a three-wire serial port, clamps it and applies it when the load
  window closes; decodes transmit enable and sleep into a power mode.
  assumes: i_mclk is a free running 50 MHz clock; the serial clock comes from
  the host and may stop between loads; power-up is modelled by i_sys_rst.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_gain_control
  import gain_ctrl_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_link_clk,
  input  wire logic                    i_load_window_n,
  input  wire logic                    i_serial_gain_in,
  input  wire logic                    i_transmit_enable,
  input  wire logic                    i_sleep_n,
  output gain_ctrl_pkg::core_ctrl_s    o_core,
  output gain_ctrl_pkg::power_mode_e   o_power_mode
);

  import gain_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] clamp_code(input logic [5:0] raw);
    if (raw > CODE_MAX) begin
      clamp_code = CODE_MAX;
    end else begin
      clamp_code = raw;
    end
  endfunction

  function automatic logic signed [10:0] code_to_tenths(input logic [5:0] code);
    int tenths;
    tenths = GAIN_BASE_TENTHS + (int'(code) - int'(CODE_MIN)) * GAIN_STEP_TENTHS;
    code_to_tenths = tenths[10:0];
  endfunction

  // ----------------------------------------------------------------
  // link side: shift register on the serial clock
  // ----------------------------------------------------------------
  serial_pins_s pins;
  logic [5:0]   shift_word;

  assign pins.load_window_n  = i_load_window_n;
  assign pins.serial_gain_in = i_serial_gain_in;

  gain_code_shifter u_shifter (
    .i_link_clk (i_link_clk),
    .i_sys_rst  (i_sys_rst),
    .i_pins     (pins),
    .o_shift    (shift_word)
  );

  // ----------------------------------------------------------------
  // crossing into i_mclk
  // ----------------------------------------------------------------
  // the shift word is stable whenever the window is high (no shifting then),
  // so the window level acts as the handshake: after its rise is seen through
  // two flops, the word has long settled and is sampled through two more.
  logic       win_meta_reg,  win_meta_next;
  logic       win_sync_reg,  win_sync_next;
  logic       win_prev_reg,  win_prev_next;
  logic [5:0] word_meta_reg, word_meta_next;
  logic [5:0] word_sync_reg, word_sync_next;
  logic       tx_meta_reg,   tx_meta_next;
  logic       tx_sync_reg,   tx_sync_next;
  logic       slp_meta_reg,  slp_meta_next;
  logic       slp_sync_reg,  slp_sync_next;
  logic       win_rise;

  always_comb begin
    win_meta_next  = i_load_window_n;
    win_sync_next  = win_meta_reg;
    win_prev_next  = win_sync_reg;
    word_meta_next = shift_word;
    word_sync_next = word_meta_reg;
    tx_meta_next   = i_transmit_enable;
    tx_sync_next   = tx_meta_reg;
    slp_meta_next  = i_sleep_n;
    slp_sync_next  = slp_meta_reg;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      win_meta_reg  <= 1'b1;
      win_sync_reg  <= 1'b1;
      win_prev_reg  <= 1'b1;
      word_meta_reg <= CODE_RESET;
      word_sync_reg <= CODE_RESET;
      tx_meta_reg   <= 1'b0;
      tx_sync_reg   <= 1'b0;
      slp_meta_reg  <= 1'b1;
      slp_sync_reg  <= 1'b1;
    end else begin
      win_meta_reg  <= win_meta_next;
      win_sync_reg  <= win_sync_next;
      win_prev_reg  <= win_prev_next;
      word_meta_reg <= word_meta_next;
      word_sync_reg <= word_sync_next;
      tx_meta_reg   <= tx_meta_next;
      tx_sync_reg   <= tx_sync_next;
      slp_meta_reg  <= slp_meta_next;
      slp_sync_reg  <= slp_sync_next;
    end
  end

  // delayed two stages so the word synchroniser has caught up on the rise
  logic win_settle_reg, win_settle_next;
  assign win_rise = win_sync_reg & ~win_prev_reg;

  // ----------------------------------------------------------------
  // applied gain latch
  // ----------------------------------------------------------------
  logic [5:0] gain_reg, gain_next;
  logic       apply_pend_reg, apply_pend_next;

  always_comb begin
    gain_next       = gain_reg;
    apply_pend_next = win_rise;
    win_settle_next = apply_pend_reg;
    if (win_settle_reg) begin
      gain_next = clamp_code(word_sync_reg);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gain_reg       <= CODE_RESET;
      apply_pend_reg <= 1'b0;
      win_settle_reg <= 1'b0;
    end else begin
      gain_reg       <= gain_next;
      apply_pend_reg <= apply_pend_next;
      win_settle_reg <= win_settle_next;
    end
  end

  // ----------------------------------------------------------------
  // power mode and core outputs
  // ----------------------------------------------------------------
  // the pins are asynchronous in the analog part; here they are sampled,
  // trading three clocks of latency for a clean registered mode.
  power_mode_e mode_reg, mode_next;
  core_ctrl_s  core_reg, core_next;

  always_comb begin
    if (!slp_sync_reg) begin
      mode_next = MODE_SLEEP;
    end else if (!tx_sync_reg) begin
      mode_next = MODE_BURST_IDLE;
    end else begin
      mode_next = MODE_TRANSMIT;
    end
    core_next.gain_code      = gain_reg;
    core_next.gain_tenths_db = code_to_tenths(gain_reg);
    core_next.amp_enable     = (mode_next == MODE_TRANSMIT);
    core_next.sleep_active   = (mode_next == MODE_SLEEP);
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_reg                <= MODE_SLEEP;
      core_reg.gain_code      <= CODE_RESET;
      core_reg.gain_tenths_db <= 11'(GAIN_BASE_TENTHS);
      core_reg.amp_enable     <= 1'b0;
      core_reg.sleep_active   <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      core_reg <= core_next;
    end
  end

  assign o_core       = core_reg;
  assign o_power_mode = mode_reg;

endmodule
`default_nettype wire

/* shared/gain_ctrl_pkg.sv */
/*
  gain_ctrl_pkg: shared constants and types for the serial gain control block.
  assumes: included before any design file that uses it; no clocks or resets here.
*/
package gain_ctrl_pkg;

  // ----------------------------------------------------------------
  // gain code layout
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W     = 6;
  localparam logic [5:0]  CODE_MIN   = 6'h01;
  localparam logic [5:0]  CODE_MAX   = 6'h3c;
  localparam logic [5:0]  CODE_RESET = 6'h01;

  // attenuator step in tenths of a decibel; code 1 sits at -25.5 dB
  localparam int          GAIN_STEP_TENTHS = 10;
  localparam int          GAIN_BASE_TENTHS = -255;
  localparam int unsigned GAIN_DB_W        = 11;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_BURST_IDLE,
    MODE_TRANSMIT
  } power_mode_e;

  // pins as seen from the host, before synchronising
  typedef struct packed {
    logic load_window_n;
    logic serial_gain_in;
  } serial_pins_s;

  // what the analog core is driven with
  typedef struct packed {
    logic [5:0]           gain_code;
    logic signed [10:0]   gain_tenths_db;
    logic                 amp_enable;
    logic                 sleep_active;
  } core_ctrl_s;

endpackage

/* testbench/gain_host.sv */
/* gain_host: host side of the three-wire gain port.
   assumes: the bench waits at least six system clocks after each send and touch. */
`timescale 1ns/10ps
`default_nettype none
module gain_host (
  output logic o_link_clk,
  output logic o_win_n,
  output logic o_sdat
);
  // ------
  // frames
  // ------
  initial begin
    o_link_clk = 1'b0;
    o_win_n    = 1'b1;
    o_sdat     = 1'b0;
  end
  // clock stands still between frames; released data flips so stale bits never look valid
  task automatic send(input logic [7:0] w);
    o_win_n = 1'b0;
    for (int k = 7; k >= 0; k--) begin
      o_sdat = w[k];
      #6 o_link_clk = 1'b1;
      #6 o_link_clk = 1'b0;
    end
    #6 o_win_n = 1'b1;
    o_sdat = ~o_sdat;
  endtask
  // window opened and closed with no clock, long enough for two system clocks to see it
  task automatic touch();
    o_win_n = 1'b0;
    #60 o_win_n = 1'b1;
  endtask
  // a pulse outside any frame
  task automatic stray();
    o_sdat = ~o_sdat;
    #6 o_link_clk = 1'b1;
    #6 o_link_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/serial_gain_control_asserts.sv */
/* serial_gain_control_asserts: port checks of the gain block.
   assumes: bound into serial_gain_control; only i_mclk timing is checked. */
`timescale 1ns/10ps
`default_nettype none
module serial_gain_control_asserts
  import gain_ctrl_pkg::*;
(
  input wire logic                       i_mclk,
  input wire logic                       i_sys_rst,
  input wire logic                       i_load_window_n,
  input wire logic                       i_transmit_enable,
  input wire logic                       i_sleep_n,
  input wire gain_ctrl_pkg::core_ctrl_s  o_core,
  input wire gain_ctrl_pkg::power_mode_e o_power_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // edges seen since the window closed, saturating
  logic [3:0] since_rise;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) since_rise <= 4'hf;
    else if (!i_load_window_n) since_rise <= 4'h0;
    else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
  end
  sequence tx_held; (i_sleep_n && i_transmit_enable) [*5]; endsequence
  sequence idle_held; (i_sleep_n && !i_transmit_enable) [*5]; endsequence
  sequence sleep_held; !i_sleep_n [*5]; endsequence
  a_reset_gain_one: assert property (
    $fell(i_sys_rst) |-> o_core.gain_code == CODE_RESET && o_power_mode == MODE_SLEEP)
    else $error("gain not at code one after reset");
  a_code_clamped: assert property (o_core.gain_code <= CODE_MAX)
    else $error("gain code above sixty");
  a_db_per_code: assert property (
    o_core.gain_tenths_db == 11'(GAIN_BASE_TENTHS + GAIN_STEP_TENTHS * (int'(o_core.gain_code) - 1)))
    else $error("gain in tenths does not follow code");
  a_change_after_rise: assert property (
    $changed(o_core.gain_code) |-> since_rise inside {[4'h3:4'hb]})
    else $error("gain changed away from a window close");
  a_tx_mode: assert property (tx_held |-> o_power_mode == MODE_TRANSMIT && o_core.amp_enable)
    else $error("transmit mode not reached");
  a_idle_mode: assert property (idle_held |-> o_power_mode == MODE_BURST_IDLE && !o_core.amp_enable)
    else $error("between burst mode not reached");
  a_sleep_wins: assert property (sleep_held |-> o_power_mode == MODE_SLEEP && o_core.sleep_active)
    else $error("sleep not entered");
  a_sleep_amp_off: assert property (
    o_core.sleep_active |-> !o_core.amp_enable && o_power_mode == MODE_SLEEP)
    else $error("amplifier on in sleep");
endmodule
bind serial_gain_control serial_gain_control_asserts chk_u (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_load_window_n(i_load_window_n),
  .i_transmit_enable(i_transmit_enable), .i_sleep_n(i_sleep_n), .o_core(o_core),
  .o_power_mode(o_power_mode));
`default_nettype wire

/* testbench/testbench.sv */
/* testbench: self-checking bench of serial_gain_control.
   assumes: gain_host stands in for the host controller on the link. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench
  import gain_ctrl_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_transmit_enable = 1'b0;
  logic        i_sleep_n = 1'b1;
  wire logic   link_clk, win_n, sdat;
  core_ctrl_s  o_core;
  power_mode_e o_power_mode;
  int          mismatches = 0;
  int          n_tests = 0;
  always #10 i_mclk = ~i_mclk;
  gain_host host_u (.o_link_clk(link_clk), .o_win_n(win_n), .o_sdat(sdat));
  serial_gain_control dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_link_clk(link_clk),
    .i_load_window_n(win_n), .i_serial_gain_in(sdat), .i_transmit_enable(i_transmit_enable),
    .i_sleep_n(i_sleep_n), .o_core(o_core), .o_power_mode(o_power_mode));
  // ------
  // tests
  // ------
  task automatic t_reset();
    `CHK("gain", CODE_RESET, o_core.gain_code)
    `CHK("tenths", 11'(GAIN_BASE_TENTHS), o_core.gain_tenths_db)
    $display("reset test done");
  endtask
  task automatic t_loads();
    logic [7:0] words [9] = '{8'h4b, 8'h01, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'hc5, 8'h80, 8'h2a};
    logic [5:0] c;
    foreach (words[i]) begin
      c = (words[i][5:0] > CODE_MAX) ? CODE_MAX : words[i][5:0];
      host_u.send(words[i]);
      repeat (10) @(negedge i_mclk);
      `CHK("gain", c, o_core.gain_code)
      `CHK("tenths", 11'(GAIN_BASE_TENTHS + GAIN_STEP_TENTHS * (int'(c) - 1)), o_core.gain_tenths_db)
    end
    $display("load test done");
  endtask
  task automatic t_stray();
    repeat (3) host_u.stray();
    // an empty window re-applies the register, so any stray shift would show
    host_u.touch();
    repeat (10) @(negedge i_mclk);
    `CHK("gain", 6'h2a, o_core.gain_code)
    $display("stray clock test done");
  endtask
  task automatic t_rereset();
    host_u.send(8'h15);
    repeat (10) @(negedge i_mclk);
    `CHK("gain", 6'h15, o_core.gain_code)
    i_sys_rst = 1'b1;
    repeat (3) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    `CHK("gain", CODE_RESET, o_core.gain_code)
    `CHK("mode", MODE_SLEEP, o_power_mode)
    host_u.touch();
    repeat (10) @(negedge i_mclk);
    `CHK("gain", CODE_RESET, o_core.gain_code)
    $display("mid-run reset test done");
  endtask
  task automatic t_power();
    power_mode_e m;
    for (int k = 0; k < 4; k++) begin
      {i_sleep_n, i_transmit_enable} = 2'(k);
      repeat (6) @(negedge i_mclk);
      m = !i_sleep_n ? MODE_SLEEP : (i_transmit_enable ? MODE_TRANSMIT : MODE_BURST_IDLE);
      `CHK("mode", m, o_power_mode)
      `CHK("amp", (m == MODE_TRANSMIT), o_core.amp_enable)
      `CHK("sleep", !i_sleep_n, o_core.sleep_active)
    end
    $display("power test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset();
    // gain is set while transmit enable is still low
    t_loads();
    t_stray();
    t_rereset();
    t_power();
    conclude();
  end
  // the whole run needs a few microseconds
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
